// ### verilog/sacs_pkg.sv
// How it works
// - offset coefficient per set is a 16-bit two's complement value
// - gain coefficient per set is 16-bit unsigned with one integer bit
// - calibrated result is raw minus offset, then divided by the gain
// - four coefficient sets; channels 4, 5, 6 use sets 0, 1, 2
// - calibration code 0x1 converts, stores offset coefficient, exits by itself
// - calibration code 0x3 converts, overwrites gain coefficient, exits by itself
// - stored offset makes the zero-scale input give a zero calibrated output
// - gain determination maps reference input up to 1.25 full scale to target
// - coefficients stay host writable so averaged values can be written back
// - calibrated value is multiplied by scaling then shifted by the selector
// - four scaling and selector sets; channels 4 to 6 reuse sets 0 to 2
// - scan mode, first channel and last channel share one configuration register
// - scan writes wait in a holding buffer if it is empty, moved at next conversion start; a write while it is full is dropped
// - mode 0 converts only the first channel, without end
// - mode 1 converts first to last once, then goes to standby
// - mode 2 converts first to last and repeats
// - mode 3 drives burnout only into the channel just converted
// - burnout works in all modes, gated by each channel's enable bit
// - modes 0 to 2 drive burnout into every enabled channel at once
// - background calibration mode is held and passed to the converter core
package sacs_pkg;
    localparam logic [6:0] ADDR_BGCAL = 7'h10;
    localparam logic [6:0] ADDR_SCALCTL = 7'h17;
    localparam logic [6:0] ADDR_SCAN_STS = 7'h1E;
    localparam logic [6:0] ADDR_SCAN = 7'h1F;
    localparam logic [6:0] ADDR_INP_BASE = 7'h20;
    localparam logic [6:0] ADDR_INP_LAST = 7'h26;
    localparam logic [1:0] COEF_PAGE = 2'h3;
    localparam logic [2:0] ITEM_OFF_L = 3'h0;
    localparam logic [2:0] ITEM_OFF_H = 3'h1;
    localparam logic [2:0] ITEM_GAIN_L = 3'h2;
    localparam logic [2:0] ITEM_GAIN_H = 3'h3;
    localparam logic [2:0] ITEM_SCALE = 3'h4;
    localparam logic [2:0] ITEM_BSEL = 3'h5;
    localparam int INP_BURN_BIT = 7;
    localparam int NCH = 7;
    localparam int NSET = 4;
    localparam logic [2:0] CH_MAX = 3'h6;
    localparam logic [15:0] OFF_RST = 16'h0000;
    localparam logic [15:0] GAIN_RST = 16'h8000;
    localparam logic [7:0] SCALE_RST = 8'h01;
    localparam logic [2:0] BSEL_RST = 3'h0;
    localparam logic [1:0] BGCAL_RST = 2'h0;
    localparam logic [1:0] CAL_IDLE = 2'h0;
    localparam logic [1:0] CAL_OFFSET = 2'h1;
    localparam logic [1:0] CAL_GAIN = 2'h3;
    localparam logic [1:0] MODE0 = 2'h0;
    localparam logic [1:0] MODE1 = 2'h1;
    localparam logic [1:0] MODE2 = 2'h2;
    localparam logic [1:0] MODE3 = 2'h3;
    localparam int GAIN_FRAC = 15;
    localparam logic [5:0] DIV_STEPS = 6'h20;
    localparam logic [31:0] POS_MAX = 32'h0000_7FFF;
    localparam logic [31:0] NEG_MAX = 32'h0000_8000;
    localparam logic [31:0] U16_MAX = 32'h0000_FFFF;
    typedef struct packed {
        logic [1:0] mode;
        logic [2:0] last;
        logic [2:0] first;
    } sacs_scan_cfg_t;
    localparam sacs_scan_cfg_t SCAN_RST = 8'h00;
    typedef enum logic [2:0] {
        S_IDLE = 3'b001,
        S_CONV = 3'b010,
        S_DIV = 3'b100
    } sacs_state_t;
endpackage

// ### verilog/sacs_div.sv
`timescale 1ns/100ps
module sacs_div import sacs_pkg::*; (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic start,
    input wire logic [31:0] num,
    input wire logic [15:0] den,
    output logic busy,
    output logic done,
    output logic [31:0] quo
);
    logic [16:0] rem_reg;
    logic [5:0] cnt_reg;
    logic [16:0] trial;
    logic fits;

    // restoring step: one quotient bit per cycle, zero divisor saturates
    assign trial = {rem_reg[15:0], quo[31]};
    assign fits = trial >= {1'b0, den};

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rem_reg <= 17'h00000;
            quo <= 32'h0000_0000;
            cnt_reg <= 6'h00;
            busy <= 1'b0;
            done <= 1'b0;
        end else if (ce) begin
            done <= 1'b0;
            if (start) begin
                rem_reg <= 17'h00000;
                quo <= num;
                cnt_reg <= DIV_STEPS;
                busy <= 1'b1;
            end else if (busy) begin
                rem_reg <= fits ? (trial - {1'b0, den}) : trial;
                quo <= {quo[30:0], fits};
                cnt_reg <= cnt_reg - 6'h01;
                if (cnt_reg == 6'h01) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end
endmodule

// ### verilog/sacs_seq.sv
`timescale 1ns/100ps
module sacs_seq import sacs_pkg::*; (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic reg_wr,
    input wire logic [6:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic conv_start,
    output logic [2:0] conv_ch,
    input wire logic conv_done,
    input wire logic [15:0] conv_raw,
    output logic [15:0] data_out,
    output logic data_valid,
    output logic [2:0] data_ch,
    output logic [6:0] burnout,
    output logic [1:0] bgcal_mode,
    output logic standby
);
    // channels 4..6 fold onto sets 0..2, which are their two low bits
    function automatic logic [1:0] coef_set(input logic [2:0] ch);
        coef_set = ch[1:0];
    endfunction

    logic [15:0] off_mem [0:NSET-1];
    logic [15:0] gain_mem [0:NSET-1];
    logic [7:0] scale_mem [0:NSET-1];
    logic [2:0] bsel_mem [0:NSET-1];
    sacs_scan_cfg_t act_reg;
    sacs_scan_cfg_t pend_cfg_reg;
    logic pend_reg;
    logic run_reg;
    logic [1:0] cal_reg;
    logic [1:0] cal_act_reg;
    logic [1:0] bg_reg;
    logic [6:0] burn_en_reg;
    sacs_state_t state_reg;
    logic [2:0] nxt_ch_reg;
    logic [2:0] scan_last_channel_reg;
    logic last_vld_reg;
    logic neg_reg;

    // register decode
    logic wr_scan;
    logic wr_scal;
    logic wr_bg;
    logic wr_inp;
    logic wr_coef;
    logic [6:0] inp_off;
    logic [2:0] inp_idx;
    logic [1:0] coef_sel;
    logic [2:0] coef_item;
    assign wr_scan = reg_wr && (reg_addr == ADDR_SCAN);
    assign wr_scal = reg_wr && (reg_addr == ADDR_SCALCTL);
    assign wr_bg = reg_wr && (reg_addr == ADDR_BGCAL);
    assign inp_off = reg_addr - ADDR_INP_BASE;
    assign inp_idx = inp_off[2:0];
    assign wr_inp = reg_wr && (reg_addr >= ADDR_INP_BASE) && (reg_addr <= ADDR_INP_LAST);
    assign wr_coef = reg_wr && (reg_addr[6:5] == COEF_PAGE);
    assign coef_sel = reg_addr[4:3];
    assign coef_item = reg_addr[2:0];

    // conversion start selection
    logic cal_go;
    logic go;
    logic xfer;
    sacs_scan_cfg_t act_next;
    logic [2:0] start_ch;
    assign cal_go = (cal_reg == CAL_OFFSET) || (cal_reg == CAL_GAIN);
    assign go = cal_go || run_reg || pend_reg;
    assign xfer = (state_reg == S_IDLE) && go;
    assign act_next = pend_reg ? pend_cfg_reg : act_reg;
    assign start_ch = (cal_go || pend_reg || act_next.mode == MODE0) ?
        act_next.first : nxt_ch_reg;

    // datapath: offset subtract, divide by 1.15 gain, scale and shift
    logic [1:0] conv_set;
    logic signed [16:0] diff;
    logic [16:0] mag;
    logic [31:0] div_num;
    logic [15:0] div_den;
    logic div_start;
    logic div_done;
    logic [31:0] quo;
    logic [15:0] cal_val;
    logic [15:0] gain_sat;
    logic signed [24:0] prod;
    logic signed [24:0] shifted;
    logic off_done;
    logic gain_done;
    logic out_done;
    assign conv_set = coef_set(conv_ch);
    assign diff = $signed({conv_raw[15], conv_raw}) -
        $signed({off_mem[conv_set][15], off_mem[conv_set]});
    assign mag = diff[16] ? (17'h00000 - diff) : diff;
    assign div_num = {mag[16:0], 15'h0000};
    assign div_den = gain_mem[conv_set];
    assign off_done = (state_reg == S_CONV) && conv_done && (cal_act_reg == CAL_OFFSET);
    assign div_start = (state_reg == S_CONV) && conv_done && (cal_act_reg != CAL_OFFSET);
    assign gain_done = (state_reg == S_DIV) && div_done && (cal_act_reg == CAL_GAIN);
    assign out_done = (state_reg == S_DIV) && div_done && (cal_act_reg == CAL_IDLE);
    assign cal_val = !neg_reg ? ((quo > POS_MAX) ? 16'h7FFF : quo[15:0]) :
        ((quo > NEG_MAX) ? 16'h8000 : (16'h0000 - quo[15:0]));
    assign gain_sat = (quo > U16_MAX) ? 16'hFFFF : quo[15:0];
    assign prod = $signed(cal_val) * $signed({1'b0, scale_mem[conv_set]});
    assign shifted = prod >>> bsel_mem[conv_set];

    sacs_div u_div (
        .mclk(mclk),
        .nrst(nrst),
        .ce(ce),
        .start(div_start),
        .num(div_num),
        .den(div_den),
        .busy(),
        .done(div_done),
        .quo(quo)
    );

    // scan advance
    logic wrap;
    logic [2:0] ch_inc;
    assign wrap = (conv_ch == act_reg.last) || (conv_ch == CH_MAX);
    assign ch_inc = conv_ch + 3'h1;

    // coefficient sets: hardware determination wins over a host write
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < NSET; i++) begin
                off_mem[i] <= OFF_RST;
                gain_mem[i] <= GAIN_RST;
                scale_mem[i] <= SCALE_RST;
                bsel_mem[i] <= BSEL_RST;
            end
        end else if (ce) begin
            if (wr_coef) begin
                case (coef_item)
                    ITEM_OFF_L: off_mem[coef_sel][7:0] <= reg_wdata;
                    ITEM_OFF_H: off_mem[coef_sel][15:8] <= reg_wdata;
                    ITEM_GAIN_L: gain_mem[coef_sel][7:0] <= reg_wdata;
                    ITEM_GAIN_H: gain_mem[coef_sel][15:8] <= reg_wdata;
                    ITEM_SCALE: scale_mem[coef_sel] <= reg_wdata;
                    ITEM_BSEL: bsel_mem[coef_sel] <= reg_wdata[2:0];
                    default: ;
                endcase
            end
            if (off_done) begin
                off_mem[conv_set] <= conv_raw;
            end
            if (gain_done) begin
                gain_mem[conv_set] <= gain_sat;
            end
        end
    end

    // configuration registers
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            bg_reg <= BGCAL_RST;
            burn_en_reg <= 7'h00;
            pend_cfg_reg <= SCAN_RST;
            pend_reg <= 1'b0;
        end else if (ce) begin
            if (wr_bg) begin
                bg_reg <= reg_wdata[1:0];
            end
            if (wr_inp) begin
                burn_en_reg[inp_idx] <= reg_wdata[INP_BURN_BIT];
            end
            if (wr_scan && !pend_reg) begin
                pend_cfg_reg <= reg_wdata;
                pend_reg <= 1'b1;
            end else if (xfer) begin
                pend_reg <= 1'b0;
            end
        end
    end

    // calibration control field: host write wins over the automatic exit
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cal_reg <= CAL_IDLE;
        end else if (ce) begin
            if (wr_scal) begin
                cal_reg <= reg_wdata[1:0];
            end else if (off_done || gain_done) begin
                cal_reg <= CAL_IDLE;
            end
        end
    end

    // conversion sequencer
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= S_IDLE;
            act_reg <= SCAN_RST;
            run_reg <= 1'b1;
            conv_start <= 1'b0;
            conv_ch <= 3'h0;
            cal_act_reg <= CAL_IDLE;
            neg_reg <= 1'b0;
        end else if (ce) begin
            conv_start <= 1'b0;
            unique case (state_reg)
                S_IDLE: begin
                    if (go) begin
                        act_reg <= act_next;
                        if (pend_reg) begin
                            run_reg <= 1'b1;
                        end
                        conv_start <= 1'b1;
                        conv_ch <= start_ch;
                        cal_act_reg <= cal_go ? cal_reg : CAL_IDLE;
                        state_reg <= S_CONV;
                    end
                end
                S_CONV: begin
                    if (conv_done) begin
                        neg_reg <= diff[16];
                        state_reg <= off_done ? S_IDLE : S_DIV;
                    end
                end
                S_DIV: begin
                    if (div_done) begin
                        state_reg <= S_IDLE;
                        if (out_done && act_reg.mode == MODE1 && wrap) begin
                            run_reg <= 1'b0;
                        end
                    end
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end

    // scan position, result output and last converted channel
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            nxt_ch_reg <= 3'h0;
            data_out <= 16'h0000;
            data_valid <= 1'b0;
            data_ch <= 3'h0;
            scan_last_channel_reg <= 3'h0;
            last_vld_reg <= 1'b0;
        end else if (ce) begin
            data_valid <= 1'b0;
            if (out_done) begin
                data_out <= shifted[15:0];
                data_valid <= 1'b1;
                data_ch <= conv_ch;
                if (act_reg.mode == MODE0 || wrap) begin
                    nxt_ch_reg <= act_reg.first;
                end else begin
                    nxt_ch_reg <= ch_inc;
                end
            end
            if ((state_reg == S_CONV) && conv_done) begin
                scan_last_channel_reg <= conv_ch;
                last_vld_reg <= 1'b1;
            end
        end
    end

    // burnout gating
    logic [6:0] last_hot;
    assign last_hot = 7'h01 << scan_last_channel_reg;
    assign burnout = (act_reg.mode == MODE3) ?
        (last_vld_reg ? (burn_en_reg & last_hot) : 7'h00) :
        burn_en_reg;
    assign bgcal_mode = bg_reg;
    assign standby = (state_reg == S_IDLE) && !go;

    // read-back
    logic [7:0] coef_rd;
    logic [7:0] rd_val;
    logic [7:0] inp_rd;
    assign coef_rd = (coef_item == ITEM_OFF_L) ? off_mem[coef_sel][7:0] :
        (coef_item == ITEM_OFF_H) ? off_mem[coef_sel][15:8] :
        (coef_item == ITEM_GAIN_L) ? gain_mem[coef_sel][7:0] :
        (coef_item == ITEM_GAIN_H) ? gain_mem[coef_sel][15:8] :
        (coef_item == ITEM_SCALE) ? scale_mem[coef_sel] :
        (coef_item == ITEM_BSEL) ? {5'h00, bsel_mem[coef_sel]} : 8'h00;
    assign inp_rd = {burn_en_reg[inp_idx], 7'h00};
    assign rd_val = (reg_addr[6:5] == COEF_PAGE) ? coef_rd :
        (reg_addr == ADDR_SCAN) ? act_reg :
        (reg_addr == ADDR_SCAN_STS) ? {7'h00, pend_reg} :
        (reg_addr == ADDR_SCALCTL) ? {6'h00, cal_reg} :
        (reg_addr == ADDR_BGCAL) ? {6'h00, bg_reg} :
        ((reg_addr >= ADDR_INP_BASE) && (reg_addr <= ADDR_INP_LAST)) ? inp_rd : 8'h00;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 8'h00;
        end else if (ce) begin
            reg_rdata <= rd_val;
        end
    end

    // checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);

    sequence s_off_done;
        ce && off_done;
    endsequence
    sequence s_gain_done;
        ce && gain_done && !wr_scal;
    endsequence
    sequence s_zero_in;
        ce && (state_reg == S_CONV) && conv_done && (cal_act_reg == CAL_IDLE) &&
            (conv_raw == off_mem[conv_set]);
    endsequence

    a_off_store: assert property (s_off_done |=> (off_mem[conv_set] == $past(conv_raw)) && (cal_reg == CAL_IDLE || $past(wr_scal)))
        else $error("offset coefficient not stored on determination");
    a_gain_store: assert property (s_gain_done |=> (gain_mem[conv_set] == $past(gain_sat)) && (cal_reg == CAL_IDLE))
        else $error("gain coefficient not stored or mode not exited");
    a_zero_out: assert property (s_zero_in |-> ##[1:40] (data_valid && data_out == 16'h0000))
        else $error("zero-scale input did not give zero output");
    a_pend_hold: assert property (ce && wr_scan && pend_reg |=> pend_cfg_reg == $past(pend_cfg_reg))
        else $error("scan write accepted while holding buffer full");
    a_pend_xfer: assert property (ce && xfer && pend_reg |=> (act_reg == $past(pend_cfg_reg)) && !pend_reg)
        else $error("scan configuration not moved at conversion start");
    a_mode0_chan: assert property (conv_start && act_reg.mode == MODE0 |-> conv_ch == act_reg.first)
        else $error("mode 0 converted a channel other than the first");
    a_mode1_stop: assert property (ce && out_done && act_reg.mode == MODE1 && wrap && !pend_reg |=> !run_reg ##1 !conv_start)
        else $error("single pass scan did not stop after last channel");
    a_mode2_next: assert property (data_valid && act_reg.mode == MODE2 && data_ch != act_reg.last && data_ch != CH_MAX |-> nxt_ch_reg == data_ch + 3'h1)
        else $error("continuous scan skipped a channel");
    a_burn_direct: assert property (act_reg.mode != MODE3 |-> burnout == burn_en_reg)
        else $error("burnout differs from enables outside mode 3");
    a_burn_serial: assert property (act_reg.mode == MODE3 |-> $onehot0(burnout) && ((burnout & ~burn_en_reg) == 7'h00))
        else $error("mode 3 burnout on more than one or a disabled channel");
endmodule

// ### dv/tb.sv
`timescale 1ns/100ps
module tb import sacs_pkg::*; ;
    logic mclk, nrst, ce, reg_wr, conv_done;
    logic [6:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic conv_start, data_valid, standby;
    logic [2:0] conv_ch, data_ch;
    logic [15:0] conv_raw, data_out;
    logic [6:0] burnout;
    logic [1:0] bgcal_mode;
    int n_fail, samples_checked, cycles;
    logic [2:0] scan_ch [4] = '{3'h4, 3'h5, 3'h6, 3'h4};
    logic [15:0] scan_exp [4] = '{16'h0200, 16'h0030, 16'h0020, 16'h0200};

    sacs_seq i_dut (
        .mclk(mclk),
        .nrst(nrst),
        .ce(ce),
        .reg_wr(reg_wr),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata),
        .conv_start(conv_start),
        .conv_ch(conv_ch),
        .conv_done(conv_done),
        .conv_raw(conv_raw),
        .data_out(data_out),
        .data_valid(data_valid),
        .data_ch(data_ch),
        .burnout(burnout),
        .bgcal_mode(bgcal_mode),
        .standby(standby)
    );

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    task automatic close_out;
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // hang guard, well above the fewer than a thousand cycles the sequence needs
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 8000) begin
            n_fail++;
            $display("CHECK FAILED at %0t: run did not finish", $time);
            close_out();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic bo(input logic [6:0] e);
        chk({9'h000, burnout}, {9'h000, e}, "burnout enables");
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(negedge mclk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge mclk);
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask

    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        @(negedge mclk);
        reg_addr = a;
        @(negedge mclk);
        chk({8'h00, reg_rdata}, {8'h00, e}, "register read");
    endtask

    // wait for the core to be asked for a conversion of channel ch
    task automatic cs(input logic [2:0] ch);
        int n;
        n = 0;
        @(negedge mclk);
        while (conv_start !== 1'b1 && n < 200) begin
            @(negedge mclk);
            n++;
        end
        chk({15'h0000, conv_start}, 16'h0001, "conversion start");
        chk({13'h0000, conv_ch}, {13'h0000, ch}, "conversion channel");
    endtask

    // finish the pending conversion, optionally expect the calibrated result
    task automatic fin(input logic [15:0] raw, input logic [15:0] e, input logic has_data,
                       input logic [2:0] ch);
        int n;
        n = 0;
        @(negedge mclk);
        conv_done = 1'b1;
        conv_raw = raw;
        @(negedge mclk);
        conv_done = 1'b0;
        conv_raw = ~raw;
        if (has_data) begin
            while (data_valid !== 1'b1 && n < 200) begin
                @(negedge mclk);
                n++;
            end
            chk({15'h0000, data_valid}, 16'h0001, "result strobe");
            chk(data_out, e, "result value");
            chk({13'h0000, data_ch}, {13'h0000, ch}, "result channel");
        end
    endtask

    initial begin
        nrst = 1'b0;
        ce = 1'b1;
        reg_wr = 1'b0;
        reg_addr = 7'h00;
        reg_wdata = 8'h00;
        conv_done = 1'b0;
        conv_raw = 16'h0000;
        n_fail = 0;
        samples_checked = 0;
        cycles = 0;
        repeat (2) @(negedge mclk);
        nrst = 1'b1;
        cs(3'h0);
        rd(7'h60, 8'h00);
        rd(7'h62, 8'h00);
        rd(7'h63, 8'h80);
        rd(7'h64, 8'h01);
        rd(7'h65, 8'h00);
        rd(ADDR_SCAN, 8'h00);
        rd(ADDR_SCALCTL, 8'h00);
        wr(7'h05, 8'hFF);
        rd(7'h05, 8'h00);
        wr(ADDR_BGCAL, 8'h02);
        rd(ADDR_BGCAL, 8'h02);
        chk({14'h0000, bgcal_mode}, 16'h0002, "background mode");
        wr(7'h60, 8'hF0);
        wr(7'h61, 8'hFF);
        rd(7'h60, 8'hF0);
        rd(7'h61, 8'hFF);
        fin(16'h0010, 16'h0020, 1'b1, 3'h0);
        cs(3'h0);
        wr(7'h62, 8'h00);
        wr(7'h63, 8'h40);
        wr(7'h64, 8'h08);
        wr(7'h65, 8'h01);
        fin(16'h0030, 16'h0200, 1'b1, 3'h0);
        cs(3'h0);
        wr(ADDR_SCAN, 8'hB4);
        rd(ADDR_SCAN_STS, 8'h01);
        wr(ADDR_SCAN, 8'h00);
        rd(ADDR_SCAN, 8'h00);
        wr(7'h21, 8'h80);
        wr(7'h25, 8'h80);
        wr(7'h70, 8'h10);
        bo(7'h22);
        fin(16'h0030, 16'h0200, 1'b1, 3'h0);
        for (int i = 0; i < 4; i++) begin
            cs(scan_ch[i]);
            if (i == 3) begin
                rd(ADDR_SCAN_STS, 8'h00);
                rd(ADDR_SCAN, 8'hB4);
            end
            fin(16'h0030, scan_exp[i], 1'b1, scan_ch[i]);
        end
        cs(3'h5);
        wr(7'h21, 8'h00);
        wr(ADDR_SCAN, 8'hEC);
        bo(7'h20);
        fin(16'h0030, 16'h0030, 1'b1, 3'h5);
        cs(3'h4);
        bo(7'h20);
        fin(16'h0030, 16'h0200, 1'b1, 3'h4);
        cs(3'h5);
        bo(7'h00);
        wr(ADDR_SCAN, 8'h51);
        fin(16'h0030, 16'h0030, 1'b1, 3'h5);
        cs(3'h1);
        fin(16'h0030, 16'h0030, 1'b1, 3'h1);
        cs(3'h2);
        fin(16'h0030, 16'h0020, 1'b1, 3'h2);
        repeat (6) begin
            @(negedge mclk);
            chk({15'h0000, conv_start}, 16'h0000, "start after single pass");
        end
        chk({15'h0000, standby}, 16'h0001, "standby");
        // clock enable low: a register write must not land
        @(negedge mclk);
        ce = 1'b0;
        wr(ADDR_BGCAL, 8'h01);
        chk({14'h0000, bgcal_mode}, 16'h0002, "frozen background mode");
        ce = 1'b1;
        rd(ADDR_BGCAL, 8'h02);
        wr(ADDR_BGCAL, 8'h00);
        chk({14'h0000, bgcal_mode}, 16'h0000, "background mode off");
        wr(ADDR_SCAN, 8'h1B);
        cs(3'h3);
        wr(ADDR_SCALCTL, 8'h01);
        fin(16'hFFD0, 16'hFFD0, 1'b1, 3'h3);
        cs(3'h3);
        fin(16'h0123, 16'h0000, 1'b0, 3'h3);
        cs(3'h3);
        rd(ADDR_SCALCTL, 8'h00);
        rd(7'h78, 8'h23);
        rd(7'h79, 8'h01);
        wr(7'h7A, 8'h00);
        wr(7'h7B, 8'h40);
        wr(ADDR_SCALCTL, 8'h03);
        fin(16'h0123, 16'h0000, 1'b1, 3'h3);
        cs(3'h3);
        fin(16'h2123, 16'h0000, 1'b0, 3'h3);
        cs(3'h3);
        rd(ADDR_SCALCTL, 8'h00);
        rd(7'h7A, 8'h00);
        rd(7'h7B, 8'h40);
        fin(16'h1123, 16'h2000, 1'b1, 3'h3);
        close_out();
    end
endmodule
